// ---- pkg/pidsv_pkg.sv ----
// Constants, register map and types for the PID sleep and feedback supervisor
package pidsv_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_TIME_NS = 100_000_000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  // Register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_LOSS = 8'h04;
  localparam logic [7:0] OFS_SLP_FREQ = 8'h08;
  localparam logic [7:0] OFS_SLP_DLY = 8'h0C;
  localparam logic [7:0] OFS_WAKE_FREQ = 8'h10;
  localparam logic [7:0] OFS_WAKE_DLY = 8'h14;
  localparam logic [7:0] OFS_SUBST = 8'h18;
  localparam logic [7:0] OFS_TGT_LIM = 8'h1C;
  localparam logic [7:0] OFS_DISP = 8'h20;
  localparam logic [7:0] OFS_FB_MAX = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_TARGET = 8'h2C;
  localparam logic [7:0] OFS_DISPLAY = 8'h30;
  localparam logic [7:0] OFS_FREQ = 8'h34;
  localparam logic [7:0] OFS_FB_ENG = 8'h38;
  // Field positions
  localparam int CFG_LOSS_LSB = 0;
  localparam int CFG_SLEEP_LSB = 2;
  localparam int CFG_COMP_BIT = 4;
  localparam int CFG_PID_LSB = 8;
  localparam int CFG_TSRC_LSB = 12;
  localparam int CFG_FSRC_LSB = 16;
  localparam int CFG_LED_BIT = 20;
  localparam int CFG_DW_LSB = 24;
  localparam int LOSS_LVL_LSB = 0;
  localparam int LOSS_TIME_LSB = 8;
  localparam int LIM_UP_LSB = 0;
  localparam int LIM_LO_LSB = 8;
  localparam int DISP_BIAS_LSB = 0;
  localparam int DISP_GAIN_LSB = 16;
  localparam int FBMAX_EN_BIT = 16;
  localparam int ST_FAULT_BIT = 0;
  // Reset values
  localparam logic [31:0] CFG_RST = 32'h0102_1000;
  localparam logic [6:0] LOSS_LVL_RST = 7'h00;
  localparam logic [6:0] LOSS_TIME_RST = 7'h0A;
  localparam logic [15:0] FREQ_RST = 16'h0000;
  localparam logic [11:0] DLY_RST = 12'h00A;
  localparam logic [6:0] LIM_UP_RST = 7'h64;
  localparam logic [6:0] LIM_LO_RST = 7'h00;
  localparam logic [15:0] BIAS_RST = 16'h0000;
  localparam logic [15:0] GAIN_RST = 16'h2710;
  localparam logic [13:0] FBMAX_RST = 14'h03E7;
  // Codes and scale figures
  localparam logic [1:0] LOSS_OFF = 2'h0;
  localparam logic [1:0] LOSS_WARN = 2'h1;
  localparam logic [1:0] LOSS_FAULT = 2'h2;
  localparam logic [1:0] SLEEP_OFF = 2'h0;
  localparam logic [1:0] SLEEP_FREQ = 2'h1;
  localparam logic [1:0] SLEEP_DI = 2'h2;
  localparam logic [13:0] PCT_SCALE = 14'h0064;
  localparam logic [27:0] PCT_FULL = 28'h000_2710;
  localparam logic [13:0] LED_FB_LIMIT = 14'h03E8;
  localparam logic [2:0] LED_DW = 3'h1;

  typedef struct packed {
    logic [2:0] dec_width;
    logic led_keypad;
    logic [2:0] fb_src;
    logic [2:0] tgt_src;
    logic [3:0] pid_mode;
    logic comp_mode;
    logic [1:0] sleep_sel;
    logic [1:0] loss_mode;
  } pidsv_cfg_t;

  typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_SLEEP} pidsv_state_t;
endpackage : pidsv_pkg

// ---- rtl/pidsv_supervisor.sv ----
// PID feedback-loss, sleep/wakeup and setting supervisor with Avalon slave
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module pidsv_supervisor
  import pidsv_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic run_cmd,
  input wire logic [13:0] fb_pct,
  input wire logic [13:0] target_pct,
  input wire logic [15:0] ref_freq,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] min_freq,
  input wire logic sleep_di,
  output logic [15:0] freq_cmd,
  output logic [15:0] start_freq,
  output logic restart,
  output logic drive_run,
  output logic fault_contact,
  output logic feedback_loss_indication,
  output logic setting_conflict_alarm,
  output logic asleep,
  output logic [13:0] target_clamped,
  output logic signed [15:0] fb_display,
  output logic [13:0] fb_eng
);
  pidsv_cfg_t cfg;
  logic [6:0] loss_lvl, loss_time, lim_up, lim_lo;
  logic [15:0] slp_freq, wake_freq, subst_freq, disp_bias, disp_gain;
  logic [11:0] slp_dly, wake_dly;
  logic [13:0] fb_max;
  logic fb_max_en;
  logic served, req, wr_go;
  logic [31:0] rd_mux;
  logic di_meta, di_sync;
  logic [20:0] tick_cnt;
  logic tick;
  logic [6:0] loss_cnt;
  logic [11:0] slp_cnt, wake_cnt;
  logic pid_act, loss_cond, loss_hit, slp_cond, slp_hit, wake_cond, wake_hit;
  logic [13:0] loss_thr, lim_hi_pct, lim_lo_pct;
  logic loss_warn, next_ind;
  pidsv_state_t state;
  logic [15:0] next_freq;

  // Bus handshake: one wait cycle, then answer
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~served;
  assign wr_go = avs_write & served;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      served <= 1'b0;
    end else begin
      served <= req & ~served;
    end
  end

  // Read data latched in the wait cycle so it stands at the answer edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (req && !served) begin
      avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
    end
  end

  // Read decode; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      OFS_CFG: rd_mux = {5'h00, cfg.dec_width, 3'h0, cfg.led_keypad, 1'b0,
                         cfg.fb_src, 1'b0, cfg.tgt_src, cfg.pid_mode, 3'h0,
                         cfg.comp_mode, cfg.sleep_sel, cfg.loss_mode};
      OFS_LOSS: rd_mux = (32'(loss_time) << LOSS_TIME_LSB) | 32'(loss_lvl);
      OFS_SLP_FREQ: rd_mux = 32'(slp_freq);
      OFS_SLP_DLY: rd_mux = 32'(slp_dly);
      OFS_WAKE_FREQ: rd_mux = 32'(wake_freq);
      OFS_WAKE_DLY: rd_mux = 32'(wake_dly);
      OFS_SUBST: rd_mux = 32'(subst_freq);
      OFS_TGT_LIM: rd_mux = (32'(lim_lo) << LIM_LO_LSB) | 32'(lim_up);
      OFS_DISP: rd_mux = {disp_gain, disp_bias};
      OFS_FB_MAX: rd_mux = (32'(fb_max_en) << FBMAX_EN_BIT) | 32'(fb_max);
      OFS_STATUS: rd_mux = {26'h0, drive_run, state == ST_HOLD, asleep,
                            setting_conflict_alarm, feedback_loss_indication,
                            fault_contact};
      OFS_TARGET: rd_mux = 32'(target_clamped);
      OFS_DISPLAY: rd_mux = {{16{fb_display[15]}}, fb_display};
      OFS_FREQ: rd_mux = 32'(freq_cmd);
      OFS_FB_ENG: rd_mux = 32'(fb_eng);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Configuration registers, written at the answer edge only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= '{CFG_RST[CFG_DW_LSB +: 3], CFG_RST[CFG_LED_BIT],
               CFG_RST[CFG_FSRC_LSB +: 3], CFG_RST[CFG_TSRC_LSB +: 3],
               CFG_RST[CFG_PID_LSB +: 4], CFG_RST[CFG_COMP_BIT],
               CFG_RST[CFG_SLEEP_LSB +: 2], CFG_RST[CFG_LOSS_LSB +: 2]};
      loss_lvl <= LOSS_LVL_RST;
      loss_time <= LOSS_TIME_RST;
      slp_freq <= FREQ_RST;
      slp_dly <= DLY_RST;
      wake_freq <= FREQ_RST;
      wake_dly <= DLY_RST;
      subst_freq <= FREQ_RST;
      lim_up <= LIM_UP_RST;
      lim_lo <= LIM_LO_RST;
      disp_bias <= BIAS_RST;
      disp_gain <= GAIN_RST;
      fb_max <= FBMAX_RST;
      fb_max_en <= 1'b0;
    end else if (wr_go) begin
      case (avs_address)
        OFS_CFG: begin
          cfg.loss_mode <= avs_writedata[CFG_LOSS_LSB +: 2];
          cfg.sleep_sel <= avs_writedata[CFG_SLEEP_LSB +: 2];
          cfg.comp_mode <= avs_writedata[CFG_COMP_BIT];
          cfg.pid_mode <= avs_writedata[CFG_PID_LSB +: 4];
          cfg.tgt_src <= avs_writedata[CFG_TSRC_LSB +: 3];
          cfg.fb_src <= avs_writedata[CFG_FSRC_LSB +: 3];
          cfg.led_keypad <= avs_writedata[CFG_LED_BIT];
          cfg.dec_width <= avs_writedata[CFG_DW_LSB +: 3];
        end
        OFS_LOSS: begin
          loss_lvl <= avs_writedata[LOSS_LVL_LSB +: 7];
          loss_time <= avs_writedata[LOSS_TIME_LSB +: 7];
        end
        OFS_SLP_FREQ: slp_freq <= avs_writedata[15:0];
        OFS_SLP_DLY: slp_dly <= avs_writedata[11:0];
        OFS_WAKE_FREQ: wake_freq <= avs_writedata[15:0];
        OFS_WAKE_DLY: wake_dly <= avs_writedata[11:0];
        OFS_SUBST: subst_freq <= avs_writedata[15:0];
        OFS_TGT_LIM: begin
          lim_up <= avs_writedata[LIM_UP_LSB +: 7];
          lim_lo <= avs_writedata[LIM_LO_LSB +: 7];
        end
        OFS_DISP: begin
          disp_bias <= avs_writedata[DISP_BIAS_LSB +: 16];
          disp_gain <= avs_writedata[DISP_GAIN_LSB +: 16];
        end
        OFS_FB_MAX: begin
          fb_max <= avs_writedata[13:0];
          fb_max_en <= avs_writedata[FBMAX_EN_BIT];
        end
        default: ;
      endcase
    end
  end

  // Sleep input comes from a pin, two flops before use
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      di_meta <= 1'b0;
      di_sync <= 1'b0;
    end else begin
      di_meta <= sleep_di;
      di_sync <= di_meta;
    end
  end

  // Tenth-second time base shared by all three timers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= 21'h000000;
    end else if (tick) begin
      tick_cnt <= 21'h000000;
    end else begin
      tick_cnt <= tick_cnt + 21'h000001;
    end
  end
  assign tick = tick_cnt == 21'(TICK_CYCLES_P - 1);

  // Comparisons feeding the timers
  assign pid_act = cfg.pid_mode[0];
  assign loss_thr = {7'h00, loss_lvl} * PCT_SCALE;
  assign loss_cond = pid_act && cfg.loss_mode != LOSS_OFF
                     && fb_pct < loss_thr;
  assign loss_hit = loss_cond && loss_cnt >= loss_time;
  assign slp_cond = pid_act && state == ST_RUN
                    && (cfg.sleep_sel == SLEEP_DI ? di_sync
                        : cfg.sleep_sel == SLEEP_FREQ
                          && out_freq < slp_freq);
  assign slp_hit = slp_cond && slp_cnt >= slp_dly;
  // Reference is still examined while asleep
  assign wake_cond = state != ST_RUN
                     && (cfg.sleep_sel == SLEEP_DI ? !di_sync
                         : ref_freq > wake_freq);
  assign wake_hit = wake_cond && wake_cnt >= wake_dly;

  // Timers clear as soon as their comparison fails
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      loss_cnt <= 7'h00;
      slp_cnt <= 12'h000;
      wake_cnt <= 12'h000;
    end else begin
      if (!loss_cond) loss_cnt <= 7'h00;
      else if (tick && !loss_hit) loss_cnt <= loss_cnt + 7'h01;
      if (!slp_cond) slp_cnt <= 12'h000;
      else if (tick && !slp_hit) slp_cnt <= slp_cnt + 12'h001;
      if (!wake_cond) wake_cnt <= 12'h000;
      else if (tick && !wake_hit) wake_cnt <= wake_cnt + 12'h001;
    end
  end

  // Fault latch: software write-one clears, a new loss wins the race
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_contact <= 1'b0;
    end else if (loss_hit && cfg.loss_mode == LOSS_FAULT) begin
      fault_contact <= 1'b1;
    end else if (wr_go && avs_address == OFS_STATUS
                 && avs_writedata[ST_FAULT_BIT]) begin
      fault_contact <= 1'b0;
    end
  end

  // Warning follows the condition; the fault keeps it lit
  assign loss_warn = loss_hit && cfg.loss_mode == LOSS_WARN;
  assign next_ind = loss_warn || fault_contact
                    || (loss_hit && cfg.loss_mode == LOSS_FAULT);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      feedback_loss_indication <= 1'b0;
    end else begin
      feedback_loss_indication <= next_ind;
    end
  end

  // Sleep state machine; PID off or sleep off forces run
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_RUN;
    end else if (!pid_act || cfg.sleep_sel == SLEEP_OFF) begin
      state <= ST_RUN;
    end else begin
      case (state)
        ST_RUN: if (slp_hit) state <= cfg.comp_mode ? ST_HOLD
                                                    : ST_SLEEP;
        ST_HOLD: if (wake_hit) state <= ST_RUN;
        ST_SLEEP: if (wake_hit) state <= ST_RUN;
        default: state <= ST_RUN;
      endcase
    end
  end

  // Restart pulse and start frequency on leaving sleep
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      restart <= 1'b0;
      start_freq <= FREQ_RST;
    end else begin
      restart <= state == ST_SLEEP && wake_hit && pid_act
                 && cfg.sleep_sel != SLEEP_OFF;
      if (state == ST_SLEEP && wake_hit) begin
        start_freq <= wake_freq < slp_freq ? slp_freq : wake_freq;
      end
    end
  end

  // Frequency command; the drive's own ramp makes the moves gradual
  always_comb begin
    next_freq = ref_freq;
    if (next_ind) begin
      next_freq = subst_freq;
    end else if (!pid_act) begin
      next_freq = ref_freq;
    end else if (state == ST_SLEEP) begin
      next_freq = 16'h0000;
    end else if (state == ST_HOLD) begin
      next_freq = slp_freq;
    end else if (cfg.comp_mode && slp_cond) begin
      next_freq = ref_freq < min_freq ? min_freq : ref_freq;
    end
  end

  // Drive outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      freq_cmd <= FREQ_RST;
      asleep <= 1'b0;
      drive_run <= 1'b0;
    end else begin
      freq_cmd <= next_freq;
      asleep <= state == ST_SLEEP;
      drive_run <= run_cmd && state != ST_SLEEP && !fault_contact
                   && !(loss_hit && cfg.loss_mode == LOSS_FAULT);
    end
  end

  // Conflict check on sources and keypad display limits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      setting_conflict_alarm <= 1'b0;
    end else begin
      setting_conflict_alarm <= cfg.tgt_src == cfg.fb_src
        || (cfg.led_keypad && !(fb_max < LED_FB_LIMIT
                                && cfg.dec_width == LED_DW));
    end
  end

  // Target clamp; upper limit wins if limits cross
  assign lim_hi_pct = {7'h00, lim_up} * PCT_SCALE;
  assign lim_lo_pct = {7'h00, lim_lo} * PCT_SCALE;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      target_clamped <= 14'h0000;
    end else if (target_pct < lim_lo_pct && lim_lo_pct <= lim_hi_pct) begin
      target_clamped <= lim_lo_pct;
    end else if (target_pct > lim_hi_pct || target_pct < lim_lo_pct) begin
      target_clamped <= lim_hi_pct;
    end else begin
      target_clamped <= target_pct;
    end
  end

  // Rounds a hundredths value to the selected decimal width
  function automatic logic signed [15:0] pidsv_round(
    input logic signed [15:0] v, input logic [2:0] dw);
    logic [16:0] mag, step, r;
    mag = v[15] ? 17'(-$signed({v[15], v})) : {1'b0, v};
    step = dw == 3'h0 ? 17'h00064 : dw == 3'h1 ? 17'h0000A : 17'h00001;
    r = ((mag + (step >> 1)) / step) * step;
    return v[15] ? 16'(-$signed(r)) : r[15:0];
  endfunction : pidsv_round

  // Display scaling; widths above two keep hundredths
  logic signed [33:0] span, prod, disp_raw;
  assign span = 34'(signed'({2'b00, disp_gain}) - signed'({{2{disp_bias[15]}},
                disp_bias}));
  assign prod = span * signed'({20'h00000, fb_pct});
  assign disp_raw = prod / signed'(34'(PCT_FULL))
                    + 34'(signed'(disp_bias));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fb_display <= 16'sh0000;
      fb_eng <= 14'h0000;
    end else begin
      fb_display <= pidsv_round(disp_raw[15:0], cfg.dec_width);
      fb_eng <= fb_max_en ? 14'((28'(fb_pct) * 28'(fb_max)) / PCT_FULL)
                          : fb_pct;
    end
  end

  // Checks
  property p_loss_off;
    @(posedge clk) disable iff (!arst_n)
      cfg.loss_mode == LOSS_OFF && !fault_contact
      |=> !feedback_loss_indication;
  endproperty
  a_loss_off: assert property (p_loss_off)
    else $error("loss shown while detection off");

  property p_loss_cause;
    @(posedge clk) disable iff (!arst_n)
      $rose(feedback_loss_indication) |-> $past(loss_cond)
      && $past(loss_cnt) >= $past(loss_time);
  endproperty
  a_loss_cause: assert property (p_loss_cause)
    else $error("loss raised without full low time");

  property p_warn_runs;
    @(posedge clk) disable iff (!arst_n)
      loss_warn && !fault_contact && run_cmd && state == ST_RUN
      |=> feedback_loss_indication && !fault_contact && drive_run;
  endproperty
  a_warn_runs: assert property (p_warn_runs)
    else $error("warning stopped the drive");

  property p_fault_stop;
    @(posedge clk) disable iff (!arst_n)
      loss_hit && cfg.loss_mode == LOSS_FAULT
      |=> fault_contact && !drive_run ##1 !drive_run;
  endproperty
  a_fault_stop: assert property (p_fault_stop)
    else $error("fault did not stop drive");

  property p_subst;
    @(posedge clk) disable iff (!arst_n)
      feedback_loss_indication && $stable(subst_freq)
      |-> freq_cmd == subst_freq;
  endproperty
  a_subst: assert property (p_subst)
    else $error("substitute frequency not applied");

  property p_sleep_entry;
    @(posedge clk) disable iff (!arst_n)
      $rose(asleep) |-> $past(slp_hit, 2) && !$past(cfg.comp_mode, 2);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entered without timer expiry");

  property p_start_freq;
    @(posedge clk) disable iff (!arst_n)
      restart && $stable(wake_freq) && $stable(slp_freq)
      |-> start_freq == (wake_freq < slp_freq ? slp_freq : wake_freq);
  endproperty
  a_start_freq: assert property (p_start_freq)
    else $error("wrong start frequency");

  property p_conflict;
    @(posedge clk) disable iff (!arst_n)
      cfg.tgt_src == cfg.fb_src |=> setting_conflict_alarm;
  endproperty
  a_conflict: assert property (p_conflict)
    else $error("source conflict not flagged");

  property p_clamp;
    @(posedge clk) disable iff (!arst_n)
      $stable(lim_up) |=> target_clamped <= $past(lim_hi_pct);
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("target above upper limit");

  property p_timer_clear;
    @(posedge clk) disable iff (!arst_n)
      !loss_cond && !slp_cond |=> loss_cnt == 7'h00 && slp_cnt == 12'h000;
  endproperty
  a_timer_clear: assert property (p_timer_clear)
    else $error("timer kept count after condition dropped");

  property p_sleep_off;
    @(posedge clk) disable iff (!arst_n)
      cfg.sleep_sel == SLEEP_OFF |=> ##1 !asleep;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("asleep with sleep disabled");
endmodule : pidsv_supervisor

// ---- test/pidsv_plant.sv ----
// Partner model: feedback sensor, PID reference and drive output stage
`timescale 1ns/1ps
module pidsv_plant (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [13:0] fb_set,
  input wire logic [15:0] ref_set,
  input wire logic drive_run,
  input wire logic [15:0] freq_cmd,
  output logic [13:0] fb_pct,
  output logic [15:0] ref_freq,
  output logic [15:0] out_freq
);
  logic [15:0] goal;
  // Sensor and reference sampled once a cycle, like a converter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fb_pct <= 14'h0000;
      ref_freq <= 16'h0000;
    end else begin
      fb_pct <= fb_set;
      ref_freq <= ref_set;
    end
  end
  // Stopped drive coasts to zero rather than holding its last speed
  assign goal = drive_run ? freq_cmd : 16'h0000;
  // Output ramps 0.5 Hz a cycle, so slow sleep waits must cover the ramp
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) out_freq <= 16'h0000;
    else if (out_freq + 16'h0032 < goal) out_freq <= out_freq + 16'h0032;
    else if (out_freq > goal + 16'h0032) out_freq <= out_freq - 16'h0032;
    else out_freq <= goal;
  end
endmodule : pidsv_plant

// ---- test/tb_pidsv_supervisor.sv ----
// Self-checking bench for the PID sleep and feedback supervisor
`timescale 1ns/1ps
module tb_pidsv_supervisor;
  import pidsv_pkg::*;
  localparam int T = 10;
  typedef struct {string nm; logic [31:0] e; logic [31:0] m;} pidsv_exp_t;
  logic clk, arst_n, avs_read, avs_write, avs_waitrequest, run_cmd;
  logic sleep_di, restart, drive_run, fault_contact, asleep;
  logic feedback_loss_indication, setting_conflict_alarm;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [13:0] fb_pct, target_pct, target_clamped, fb_eng, fb_set, lo, hi;
  logic [15:0] ref_freq, out_freq, min_freq, freq_cmd, start_freq, ref_set;
  logic signed [15:0] fb_display;
  int fail_count, n_compared, seed;
  pidsv_exp_t rq[$], sq[$];

  pidsv_supervisor #(.TICK_CYCLES_P(T)) i_pidsv_supervisor (.clk, .arst_n,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .run_cmd, .fb_pct, .target_pct, .ref_freq, .out_freq,
    .min_freq, .sleep_di, .freq_cmd, .start_freq, .restart, .drive_run,
    .fault_contact, .feedback_loss_indication, .setting_conflict_alarm,
    .asleep, .target_clamped, .fb_display, .fb_eng);
  pidsv_plant i_pidsv_plant (.clk, .arst_n, .fb_set, .ref_set, .drive_run,
    .freq_cmd, .fb_pct, .ref_freq, .out_freq);

  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // One Avalon transfer, held until waitrequest is seen low
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      k++;
      @(posedge clk);
    end
    if (k == 50) fail_count++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                    input string nm);
    rq.push_back('{nm, e, m});
    xfer(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  function automatic logic [31:0] cfg(input logic [1:0] lm, sl,
      input logic cm, led, input logic [2:0] ts, fs, dw);
    return {5'h00, dw, 3'h0, led, 1'h0, fs, 1'h0, ts, 4'h1, 3'h0, cm, sl, lm};
  endfunction : cfg
  // Read data taken at the answer edge; start frequency at restart pulse
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rq.size() > 0) begin
      chk(rq[0].nm, avs_readdata & rq[0].m, rq[0].e & rq[0].m);
      rq.delete(0);
    end
    if (restart === 1'b1 && sq.size() > 0) begin
      chk(sq[0].nm, {16'h0000, start_freq}, sq[0].e);
      sq.delete(0);
    end else if (restart === 1'b1) begin
      chk("restart", 32'h1, 32'h0);
    end
  end
  task automatic give_verdict;
    $display("Compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  // Watchdog well beyond the roughly 1000 cycles the tests need
  initial begin
    cyc(20000);
    fail_count++;
    give_verdict();
  end

  initial begin
    {avs_read, avs_write, sleep_di, arst_n} = 4'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    run_cmd = 1'b1;
    min_freq = 16'h01F4;
    fb_set = 14'h1388;
    ref_set = 16'h0BB8;
    target_pct = 14'h0000;
    seed = 32'hB98E;
    fail_count = 0;
    n_compared = 0;
    cyc(20);
    arst_n <= 1'b1;
    cyc(1);
    rd(OFS_LOSS, 32'h0000_0A00, 32'hFFFF_FFFF, "loss_reset");
    rd(OFS_CFG, CFG_RST, 32'hFFFF_FFFF, "cfg_reset");
    rd(8'hFC, 32'h0, 32'hFFFF_FFFF, "unmapped");
    // Supervision must stay off with the PID mode disabled
    wr(OFS_CFG, cfg(LOSS_FAULT, SLEEP_OFF, 0, 0, 1, 2, 2) & 32'hFFFF_FEFF);
    wr(OFS_LOSS, 32'h0000_0064);
    cyc(5);
    rd(OFS_STATUS, 32'h0, 32'h0000_0003, "pid_off");
    wr(OFS_LOSS, 32'h0000_0000);
    wr(OFS_CFG, cfg(LOSS_OFF, SLEEP_OFF, 0, 0, 3, 3, 2));
    rd(OFS_STATUS, 32'h4, 32'h4, "same_src");
    wr(OFS_CFG, cfg(LOSS_OFF, SLEEP_OFF, 0, 1, 1, 2, 1));
    rd(OFS_STATUS, 32'h0, 32'h4, "led_ok");
    wr(OFS_CFG, cfg(LOSS_OFF, SLEEP_OFF, 0, 1, 1, 2, 2));
    rd(OFS_STATUS, 32'h4, 32'h4, "led_width");
    wr(OFS_CFG, cfg(LOSS_OFF, SLEEP_OFF, 0, 1, 1, 2, 1));
    wr(OFS_FB_MAX, 32'h0001_03E8);
    rd(OFS_STATUS, 32'h4, 32'h4, "led_max");
    rd(OFS_FB_ENG, 32'd500, 32'hFFFF, "fb_eng");
    // Display: 0..100 % onto -10.00..30.00, then rounding per width
    wr(OFS_DISP, {16'd3000, 16'hFC18});
    wr(OFS_CFG, cfg(LOSS_OFF, SLEEP_OFF, 0, 0, 1, 2, 2));
    rd(OFS_DISPLAY, 32'd1000, 32'hFFFF_FFFF, "display");
    wr(OFS_DISP, {16'd10000, 16'h0000});
    fb_set <= 14'd1235;
    for (int w = 0; w < 3; w++) begin
      wr(OFS_CFG, cfg(LOSS_OFF, SLEEP_OFF, 0, 0, 1, 2, w[2:0]));
      r = (w == 0) ? 32'd1200 : (w == 1) ? 32'd1240 : 32'd1235;
      rd(OFS_DISPLAY, r, 32'hFFFF_FFFF, "round");
    end
    // Random targets against limits 20..60 %
    wr(OFS_TGT_LIM, 32'h0000_143C);
    lo = 14'd2000;
    hi = 14'd6000;
    for (int i = 0; i < 8; i++) begin
      r = $unsigned($random(seed)) % 10001;
      target_pct <= r[13:0];
      cyc(3);
      r = (r[13:0] < lo) ? lo : (r[13:0] > hi) ? hi : r;
      rd(OFS_TARGET, r, 32'h3FFF, "clamp");
    end
    // Crossed limits: the upper one wins
    wr(OFS_TGT_LIM, 32'h0000_3C14);
    target_pct <= 14'd100;
    cyc(3);
    rd(OFS_TARGET, 32'd2000, 32'h3FFF, "crossed");
    // Run request withdrawn stops the drive
    run_cmd <= 1'b0;
    cyc(2);
    rd(OFS_STATUS, 32'h0, 32'h20, "run_off");
    run_cmd <= 1'b1;
    // Loss detection off, then warning with an interrupted low spell
    wr(OFS_LOSS, 32'h0000_0332);
    wr(OFS_SUBST, 32'h0000_1388);
    fb_set <= 14'd1000;
    cyc(40);
    rd(OFS_STATUS, 32'h0, 32'h2, "loss_off");
    fb_set <= 14'd6000;
    wr(OFS_CFG, cfg(LOSS_WARN, SLEEP_OFF, 0, 0, 1, 2, 2));
    fb_set <= 14'd1000;
    cyc(15);
    fb_set <= 14'd6000;
    cyc(3);
    fb_set <= 14'd1000;
    cyc(14);
    rd(OFS_STATUS, 32'h0, 32'h2, "loss_restart");
    cyc(40);
    rd(OFS_STATUS, 32'h22, 32'h23, "warn");
    rd(OFS_FREQ, 32'd5000, 32'hFFFF, "subst");
    fb_set <= 14'd6000;
    cyc(3);
    rd(OFS_STATUS, 32'h20, 32'h23, "warn_gone");
    rd(OFS_FREQ, 32'd3000, 32'hFFFF, "resume");
    // Fault mode with zero time: latches until write-one-clear
    wr(OFS_LOSS, 32'h0000_0032);
    wr(OFS_CFG, cfg(LOSS_FAULT, SLEEP_OFF, 0, 0, 1, 2, 2));
    fb_set <= 14'd1000;
    cyc(5);
    rd(OFS_STATUS, 32'h03, 32'h23, "fault");
    fb_set <= 14'd6000;
    cyc(3);
    rd(OFS_STATUS, 32'h01, 32'h01, "fault_held");
    wr(OFS_STATUS, 32'h1);
    rd(OFS_STATUS, 32'h20, 32'h23, "fault_clr");
    // Sleep by frequency; delay long enough to outlast the start ramp
    wr(OFS_SLP_FREQ, 32'd1000);
    wr(OFS_SLP_DLY, 32'd4);
    wr(OFS_WAKE_FREQ, 32'd2000);
    wr(OFS_WAKE_DLY, 32'd2);
    wr(OFS_CFG, cfg(LOSS_OFF, SLEEP_FREQ, 0, 0, 1, 2, 2));
    cyc(70);
    for (int n = 0; n < 2; n++) begin
      ref_set <= 16'd500;
      cyc(110);
      rd(OFS_STATUS, 32'h08, 32'h28, "sleep");
      sq.push_back('{"start", (n == 0) ? 32'd2000 : 32'd1000, 32'hFFFF});
      ref_set <= 16'd3000;
      cyc(45);
      rd(OFS_STATUS, 32'h20, 32'h28, "wake");
      wr(OFS_WAKE_FREQ, 32'd500);
    end
    // Mode 1: follow down to the minimum, then hold the sleep frequency
    wr(OFS_CFG, cfg(LOSS_OFF, SLEEP_FREQ, 1, 0, 1, 2, 2));
    ref_set <= 16'd300;
    cyc(110);
    rd(OFS_STATUS, 32'h30, 32'h38, "hold");
    rd(OFS_FREQ, 32'd1000, 32'hFFFF, "hold_freq");
    ref_set <= 16'd3000;
    cyc(45);
    rd(OFS_STATUS, 32'h20, 32'h38, "hold_wake");
    // Sleep request from the digital input
    wr(OFS_CFG, cfg(LOSS_OFF, SLEEP_DI, 0, 0, 1, 2, 2));
    sleep_di <= 1'b1;
    cyc(45);
    rd(OFS_STATUS, 32'h08, 32'h28, "di_sleep");
    sq.push_back('{"di_start", 32'd1000, 32'hFFFF});
    sleep_di <= 1'b0;
    cyc(45);
    rd(OFS_STATUS, 32'h20, 32'h28, "di_wake");
    chk("pending", rq.size() + sq.size(), 32'h0);
    give_verdict();
  end
endmodule : tb_pidsv_supervisor
